// >>> include/io_diag_pkg.sv
// Package for the digital I/O station register bank.
// Assumes a single 50 MHz system clock and 16-bit register words.
package io_diag_pkg;

    localparam logic [15:0] diag_status_addr = 16'h1f3d;
    localparam logic [15:0] fault_location_addr = 16'h1f3e;
    localparam logic [15:0] input_word_addr = 16'h1f40;
    localparam logic [15:0] output_word_addr = 16'h2328;

    localparam int diag_out_short_bit = 0;
    localparam int diag_sens_under_bit = 2;
    localparam int diag_sens_surge_bit = 3;
    localparam int diag_sens_short_bit = 4;
    localparam int diag_act_under_bit = 6;
    localparam int diag_act_surge_bit = 7;
    localparam int diag_act_short_bit = 8;
    localparam int diag_overtemp_bit = 10;

    localparam logic [15:0] loc_none = 16'h0000;
    localparam logic [15:0] loc_out_group1 = 16'h0001;

    localparam logic [15:0] fault_mode_zero = 16'h0000;
    localparam logic [15:0] fault_mode_one = 16'h0001;
    localparam logic [15:0] fault_mode_hold = 16'h0002;

    localparam logic [7:0] exc_none = 8'h00;
    localparam logic [7:0] exc_illegal_address = 8'h02;

    localparam logic [15:0] output_word_reset = 16'h0000;
    localparam int in_channels = 8;
    localparam int out_channels = 4;

    localparam int clk_mhz = 50;
    localparam int ready_time_ms = 350;
    localparam int exchange_time_ms = 500;
    localparam int ready_cycles = ready_time_ms * clk_mhz * 1000;
    localparam int exchange_cycles = exchange_time_ms * clk_mhz * 1000;

    typedef struct packed {
        logic out_short;
        logic sens_under;
        logic sens_surge;
        logic sens_short;
        logic act_under;
        logic act_surge;
        logic act_short;
        logic overtemp;
    } fault_in_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] exception;
        logic [15:0] rdata_be;
    } reg_rsp_s;

    typedef enum logic [1:0] {
        boot_wait = 2'b00,
        boot_ready = 2'b01,
        boot_cyclic = 2'b10
    } boot_e;

endpackage

// >>> verilog/startup_timer.sv
// Power-on readiness counter.
// Assumes rst_b is released when supply power is applied.
`timescale 1ns/1ps
module startup_timer #(
    parameter int unsigned count = 1000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    output logic done
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic done_next;

    always_comb begin
        cnt_next = cnt_reg;
        done_next = done;
        if (!done) begin
            cnt_next = cnt_reg + 32'h0000_0001;
            if (cnt_next >= count[31:0]) begin
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 32'h0000_0000;
            done <= 1'b0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            done <= done_next;
        end
    end
endmodule

// >>> verilog/io_diag_regs.sv
// Register bank of a networked 8-input, 4-output digital I/O station.
// Assumes the protocol engine delivers decoded register requests, one per cycle at most.
//
// Behaviour
// - Any output short or overload sets diagnostic status bit 0 and the fault location gives more.
// - Sensor supply undervoltage, surge and short show in status bits 2, 3 and 4.
// - Actuator supply undervoltage, surge and short show in status bits 6, 7 and 8.
// - Device overtemperature shows in status bit 10.
// - The fault location reports a channel group code, not a channel number.
// - The fault location reads 0000 without an output short and 0001 for any short on outputs 1 to 4.
// - Input channels 1 to 8 sit in bits 0 to 7 of the input word, channel 1 in bit 0.
// - Output bits 0 to 3 drive output channels 1 to 4, and bits 4 to 7 are unused.
// - Register words go out big-endian, one data word per register.
// - Single-byte process data sits in the low byte of its register.
// - The high byte of single-byte data reads zero and is discarded on writes.
// - The device accepts connection requests within 350 ms of power-up.
// - Cyclic process data exchange is possible within 500 ms of power-up.
// - Writes to read-only registers are discarded and answered with exception 02.
// - On a fault response the outputs go to 0, to 1 or hold, as the fault mode says.
`timescale 1ns/1ps
module io_diag_regs
    import io_diag_pkg::*;
#(
    parameter int unsigned ready_count = io_diag_pkg::ready_cycles,
    parameter int unsigned exchange_count = io_diag_pkg::exchange_cycles
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire io_diag_pkg::reg_req_s req,
    output io_diag_pkg::reg_rsp_s rsp_reg,
    input wire io_diag_pkg::fault_in_s faults,
    input wire logic [io_diag_pkg::in_channels-1:0] digital_input_channel,
    input wire logic fault_response,
    input wire logic [15:0] fault_mode,
    output logic [io_diag_pkg::out_channels-1:0] digital_output_channel_reg,
    output logic [15:0] diag_status_reg,
    output logic [15:0] fault_location_reg,
    output logic connect_ready_reg,
    output logic cyclic_ready_reg
);
    import io_diag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Start-up readiness.

    logic ready_done;
    logic exchange_done;
    boot_e boot_reg;
    boot_e boot_next;
    logic connect_ready_next;
    logic cyclic_ready_next;

    startup_timer #(.count(ready_count)) u_ready_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .done(ready_done)
    );

    startup_timer #(.count(exchange_count)) u_exchange_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .done(exchange_done)
    );

    always_comb begin
        boot_next = boot_reg;
        case (boot_reg)
            boot_wait: begin
                if (ready_done) begin
                    boot_next = boot_ready;
                end
            end
            boot_ready: begin
                if (exchange_done) begin
                    boot_next = boot_cyclic;
                end
            end
            boot_cyclic: begin
                boot_next = boot_cyclic;
            end
            default: begin
                boot_next = boot_wait;
            end
        endcase
        // The flags follow the next state so that they line up with the state register.
        connect_ready_next = (boot_next != boot_wait);
        cyclic_ready_next = (boot_next == boot_cyclic);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Diagnostic status and fault location.

    logic [15:0] diag_status_next;
    logic [15:0] fault_location_next;

    always_comb begin
        diag_status_next = 16'h0000;
        diag_status_next[diag_out_short_bit] = faults.out_short;
        diag_status_next[diag_sens_under_bit] = faults.sens_under;
        diag_status_next[diag_sens_surge_bit] = faults.sens_surge;
        diag_status_next[diag_sens_short_bit] = faults.sens_short;
        diag_status_next[diag_act_under_bit] = faults.act_under;
        diag_status_next[diag_act_surge_bit] = faults.act_surge;
        diag_status_next[diag_act_short_bit] = faults.act_short;
        diag_status_next[diag_overtemp_bit] = faults.overtemp;
        // All four outputs form one group, so any short reports that group.
        fault_location_next = faults.out_short ? loc_out_group1 : loc_none;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Process data and register access.

    logic [7:0] output_byte_reg;
    logic [7:0] output_byte_next;
    logic [out_channels-1:0] digital_output_channel_next;
    reg_rsp_s rsp_next;
    logic [15:0] rdata;
    logic [7:0] exc;
    logic ready_q;

    assign ready_q = (boot_reg != boot_wait);

    always_comb begin
        output_byte_next = output_byte_reg;
        rdata = 16'h0000;
        exc = exc_none;
        case (req.addr)
            diag_status_addr: begin
                rdata = diag_status_reg;
                if (req.write) begin
                    exc = exc_illegal_address;
                end
            end
            fault_location_addr: begin
                rdata = fault_location_reg;
                if (req.write) begin
                    exc = exc_illegal_address;
                end
            end
            input_word_addr: begin
                rdata = {8'h00, digital_input_channel};
                if (req.write) begin
                    exc = exc_illegal_address;
                end
            end
            output_word_addr: begin
                rdata = {8'h00, output_byte_reg};
                if (req.write && req.valid && ready_q) begin
                    output_byte_next = req.wdata[7:0];
                end
            end
            default: begin
                exc = exc_illegal_address;
            end
        endcase
        rsp_next.valid = req.valid && ready_q;
        rsp_next.exception = exc;
        // Modbus sends the high byte first on the wire.
        rsp_next.rdata_be = (exc == exc_none && !req.write) ? rdata : 16'h0000;
    end

    always_comb begin
        digital_output_channel_next = output_byte_reg[out_channels-1:0];
        if (fault_response) begin
            case (fault_mode)
                fault_mode_zero: digital_output_channel_next = '0;
                fault_mode_one: digital_output_channel_next = '1;
                fault_mode_hold: digital_output_channel_next = digital_output_channel_reg;
                default: digital_output_channel_next = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers, one process for each group; a low clock enable freezes every group.

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_reg <= boot_wait;
            connect_ready_reg <= 1'b0;
            cyclic_ready_reg <= 1'b0;
        end else if (clk_en) begin
            boot_reg <= boot_next;
            connect_ready_reg <= connect_ready_next;
            cyclic_ready_reg <= cyclic_ready_next;
        end
    end

    // Status and location are live copies of the fault inputs, so there is nothing to clear.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_status_reg <= 16'h0000;
            fault_location_reg <= loc_none;
        end else if (clk_en) begin
            diag_status_reg <= diag_status_next;
            fault_location_reg <= fault_location_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            output_byte_reg <= output_word_reset[7:0];
            digital_output_channel_reg <= '0;
        end else if (clk_en) begin
            output_byte_reg <= output_byte_next;
            digital_output_channel_reg <= digital_output_channel_next;
        end
    end

    // The answer stands for one enabled cycle; a frozen clock also freezes the answer.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_reg <= '0;
        end else if (clk_en) begin
            rsp_reg <= rsp_next;
        end
    end
endmodule

// >>> testbench/io_diag_regs_properties.sv
// Checker for the I/O station register bank; it sees only the ports of io_diag_regs.
// Assumes one clock domain and the constants of io_diag_pkg.
`timescale 1ns/1ps
module io_diag_regs_properties
    import io_diag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire io_diag_pkg::reg_req_s req,
    input wire io_diag_pkg::reg_rsp_s rsp_reg,
    input wire io_diag_pkg::fault_in_s faults,
    input wire logic fault_response,
    input wire logic [15:0] fault_mode,
    input wire logic [3:0] digital_output_channel_reg,
    input wire logic [15:0] diag_status_reg,
    input wire logic [15:0] fault_location_reg,
    input wire logic connect_ready_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] exp_status;
    assign exp_status = {5'h00, faults.overtemp, 1'b0, faults.act_short, faults.act_surge, faults.act_under, 1'b0,
        faults.sens_short, faults.sens_surge, faults.sens_under, 1'b0, faults.out_short};
    sequence s_mode(logic [15:0] m); (clk_en && fault_response && fault_mode == m) [*2]; endsequence
    property p_status; clk_en |=> diag_status_reg == $past(exp_status); endproperty
    property p_reserved; (diag_status_reg & 16'hfa22) == 16'h0000; endproperty
    property p_location; clk_en |=> fault_location_reg == ($past(faults.out_short) ? loc_out_group1 : loc_none);
    endproperty
    property p_early; !connect_ready_reg |=> !rsp_reg.valid; endproperty
    property p_refuse; clk_en && req.valid && req.write && connect_ready_reg && req.addr != output_word_addr
        |=> rsp_reg.valid && rsp_reg.exception == exc_illegal_address; endproperty
    property p_force(logic [15:0] m, logic [3:0] v); s_mode(m) |=> digital_output_channel_reg == v; endproperty
    property p_hold; s_mode(fault_mode_hold) |=> $stable(digital_output_channel_reg); endproperty
    a_status: assert property (p_status) else $error("status word wrong");
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");
    a_location: assert property (p_location) else $error("fault location wrong");
    a_early: assert property (p_early) else $error("answer before ready");
    a_refuse: assert property (p_refuse) else $error("refused write not flagged");
    a_force_zero: assert property (p_force(fault_mode_zero, 4'h0)) else $error("outputs not 0");
    a_force_one: assert property (p_force(fault_mode_one, 4'hf)) else $error("outputs not 1");
    a_hold: assert property (p_hold) else $error("outputs not held");
endmodule
bind io_diag_regs io_diag_regs_properties i_io_diag_regs_properties (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(clk_en), .req(req), .rsp_reg(rsp_reg), .faults(faults), .fault_response(fault_response),
    .fault_mode(fault_mode), .digital_output_channel_reg(digital_output_channel_reg),
    .diag_status_reg(diag_status_reg), .fault_location_reg(fault_location_reg),
    .connect_ready_reg(connect_ready_reg));

// >>> testbench/modbus_client.sv
// Network client model that sends register requests to the I/O station register bank.
// Assumes a request is taken at the edge after it is raised and answered at that same edge.
`timescale 1ns/1ps
module modbus_client
    import io_diag_pkg::*;
(
    input wire logic sys_clk,
    input wire io_diag_pkg::reg_rsp_s rsp_reg,
    output io_diag_pkg::reg_req_s req
);
    initial req = '{valid: 1'b0, write: 1'b0, addr: 16'h0000, wdata: 16'h0000};
    // Idle cycles make the client fast or slow; released fields carry inverted values.
    task automatic xfer(input int idle, input logic w, input logic [15:0] a, input logic [15:0] d,
            output logic [7:0] exc, output logic [15:0] rdata);
        repeat (idle) @(posedge sys_clk);
        @(posedge sys_clk);
        req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
        #1;
        exc = (rsp_reg.valid === 1'b1) ? rsp_reg.exception : 8'hff;
        rdata = rsp_reg.rdata_be;
    endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the I/O station register bank.
// Assumes the client model issues every register request.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("BAD at %0t got %h exp %h", $time, got, exp); end end
module tb;
    import io_diag_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    fault_in_s faults = '0;
    logic [7:0] din = 8'h00;
    logic fault_response = 1'b0;
    logic [15:0] fault_mode = 16'h0000;
    reg_req_s req;
    reg_rsp_s rsp_reg;
    logic [3:0] dout;
    logic conn_rdy;
    logic cyc_rdy;
    logic [7:0] exc;
    logic [15:0] rd;
    int errors = 0;
    int checks_done = 0;
    int bitpos [8] = '{diag_out_short_bit, diag_sens_under_bit, diag_sens_surge_bit, diag_sens_short_bit,
        diag_act_under_bit, diag_act_surge_bit, diag_act_short_bit, diag_overtemp_bit};
    logic [15:0] ro_addr [4] = '{diag_status_addr, fault_location_addr, input_word_addr, 16'h1234};
    logic [7:0] in_vals [3] = '{8'h01, 8'ha5, 8'h80};
    logic [15:0] modes [3] = '{fault_mode_hold, fault_mode_zero, fault_mode_one};
    logic [3:0] outs [3] = '{4'h5, 4'h0, 4'hf};
    always #10 sys_clk = ~sys_clk;
    io_diag_regs #(.ready_count(20), .exchange_count(40)) i_io_diag_regs (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .req(req), .rsp_reg(rsp_reg), .faults(faults), .digital_input_channel(din),
        .fault_response(fault_response), .fault_mode(fault_mode), .digital_output_channel_reg(dout),
        .diag_status_reg(), .fault_location_reg(), .connect_ready_reg(conn_rdy), .cyclic_ready_reg(cyc_rdy));
    modbus_client i_modbus_client (.sys_clk(sys_clk), .rsp_reg(rsp_reg), .req(req));
    ////////////////////////////////////////
    task automatic rw(input logic w, input logic [15:0] a, input logic [15:0] d);
        i_modbus_client.xfer(0, w, a, d, exc, rd);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        rw(1'b0, a, 16'h0000);
        `CHK({exc, rd}, {exc_none, exp})
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(20 * 2000);
        errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rw(1'b0, input_word_addr, 16'h0000);
        `CHK(exc, 8'hff)
        for (int i = 0; i < 60 && cyc_rdy !== 1'b1; i++) @(posedge sys_clk);
        `CHK({conn_rdy, cyc_rdy}, 2'b11)
        done("startup");
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            faults <= fault_in_s'(8'h80 >> i);
            rd_chk(diag_status_addr, 16'h0001 << bitpos[i]);
            rd_chk(fault_location_addr, (i == 0) ? loc_out_group1 : loc_none);
        end
        @(posedge sys_clk);
        faults <= '1;
        rd_chk(diag_status_addr, 16'h05dd);
        @(posedge sys_clk);
        faults <= '0;
        rd_chk(fault_location_addr, loc_none);
        done("diagnostics");
        foreach (in_vals[i]) begin
            @(posedge sys_clk);
            din <= in_vals[i];
            rd_chk(input_word_addr, {8'h00, in_vals[i]});
        end
        rw(1'b1, output_word_addr, 16'hff05);
        `CHK(exc, exc_none)
        rd_chk(output_word_addr, 16'h0005);
        `CHK(dout, 4'h5)
        done("process data");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        rw(1'b1, output_word_addr, 16'h0003);
        `CHK(exc, 8'hff)
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd_chk(output_word_addr, 16'h0005);
        `CHK(dout, 4'h5)
        done("freeze");
        foreach (ro_addr[i]) begin
            rw(1'b1, ro_addr[i], 16'hffff);
            `CHK({exc, rd}, {exc_illegal_address, 16'h0000})
        end
        rw(1'b0, 16'h1234, 16'h0000);
        `CHK(exc, exc_illegal_address)
        rd_chk(input_word_addr, {8'h00, in_vals[2]});
        rd_chk(diag_status_addr, 16'h0000);
        done("refusals");
        foreach (modes[i]) begin
            @(posedge sys_clk);
            fault_response <= 1'b1;
            fault_mode <= modes[i];
            repeat (3) @(posedge sys_clk);
            #1;
            `CHK(dout, outs[i])
            rw(1'b1, output_word_addr, {12'h000, ~outs[i]});
            `CHK(dout, outs[i])
            @(posedge sys_clk);
            fault_response <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        #1;
        `CHK(dout, 4'h0)
        done("fault response");
        complete_run();
    end
endmodule
